// file: bdlu_agen.sv
// Load unit constants, shared types and the address generator
// Notes on behaviour
// - Long byte load bases on register 14 or 15
// - Long constant unshifted, always added, never subtracted
// - Long byte load addressing is always linear
// - Long byte load runs on side two only
// - Byte in low 8 bits, sign or zero fill
// - s bit picks destination file A or B
// - op 010 signed byte, 001 unsigned byte
// - Read E1, data E5, base update after one
// - Doubleword destination is even/odd pair, bit 23 zero
// - y picks unit and base/offset file together
// - Doubleword offset shifted left three, added or subtracted
// - Pre and offset modes use computed address; post use base
// - Missing offset defaults; parentheses mean unscaled bytes
// - Base four to seven may go circular
// - Little endian: low word to even, high word to odd
// - Little endian first word even, big endian odd
package bdlu_pkg;
	localparam logic [11:0] BDLU_OFF_AMR = 12'h000;
	localparam logic [11:0] BDLU_OFF_CTRL = 12'h004;
	localparam logic [11:0] BDLU_OFF_STAT = 12'h008;
	localparam logic [31:0] BDLU_AMR_RST = 32'h00000000;
	localparam logic [31:0] BDLU_CTRL_RST = 32'h00000000;
	localparam int unsigned BDLU_CTRL_BIG_ENDIAN = 0;
	localparam int unsigned BDLU_AMR_BK0_LSB = 16;
	localparam int unsigned BDLU_AMR_BK1_LSB = 21;
	localparam int unsigned BDLU_AMR_BLK_W = 5;
	localparam int unsigned BDLU_FLD_CREG_LSB = 29;
	localparam int unsigned BDLU_FLD_Z = 28;
	localparam int unsigned BDLU_FLD_DST_LSB = 23;
	localparam int unsigned BDLU_FLD_BASE_LSB = 18;
	localparam int unsigned BDLU_FLD_OFF_LSB = 13;
	localparam int unsigned BDLU_FLD_MODE_LSB = 9;
	localparam int unsigned BDLU_FLD_LCST_LSB = 8;
	localparam int unsigned BDLU_FLD_DW = 8;
	localparam int unsigned BDLU_FLD_Y = 7;
	localparam int unsigned BDLU_FLD_OP_LSB = 4;
	localparam int unsigned BDLU_FLD_FMT_LSB = 2;
	localparam int unsigned BDLU_FLD_S = 1;
	localparam logic [2:0] BDLU_OP_SBYTE = 3'h2;
	localparam logic [2:0] BDLU_OP_UBYTE = 3'h1;
	localparam logic [1:0] BDLU_FMT_LONG = 2'h3;
	localparam logic [1:0] BDLU_FMT_SHORT = 2'h1;
	localparam logic [4:0] BDLU_DDW_SIG = 5'h19;
	localparam logic [3:0] BDLU_MODE_POS_CST = 4'h1;
	localparam logic [4:0] BDLU_REG_GBASE14 = 5'h0E;
	localparam logic [4:0] BDLU_REG_BASE15 = 5'h0F;
	localparam logic [4:0] BDLU_CIRC_LO = 5'h04;
	localparam logic [4:0] BDLU_CIRC_HI = 5'h07;
	localparam int unsigned BDLU_DDW_SHIFT = 3;
	localparam int unsigned BDLU_LOAD_DELAY_SLOTS = 4;

	typedef enum logic [1:0] {
		BDLU_AMR_LINEAR = 2'b00,
		BDLU_AMR_CIRC_BK0 = 2'b01,
		BDLU_AMR_CIRC_BK1 = 2'b10,
		BDLU_AMR_RSVD = 2'b11
	} bdlu_amr_mode_t;

	typedef enum logic [1:0] {
		BDLU_KIND_NONE = 2'b00,
		BDLU_KIND_LONG = 2'b01,
		BDLU_KIND_SHORT = 2'b10,
		BDLU_KIND_DDW = 2'b11
	} bdlu_kind_t;

	typedef struct packed {
		logic valid;
		logic dw;
		logic sgn;
		logic file;
		logic [4:0] idx;
		logic [2:0] lane;
	} bdlu_ctx_t;
endpackage : bdlu_pkg

`timescale 1ns/1ps
module bdlu_agen #(
	parameter int unsigned AW = 32
) (
	input wire logic [AW-1:0] base_i, // Base register value
	input wire logic [AW-1:0] off_i, // Scaled offset
	input wire logic sub_i, // Subtract instead of add
	input wire logic circ_i, // Circular arithmetic
	input wire logic [4:0] blk_n_i, // Block size is 2^(n+1) bytes
	output logic [AW-1:0] addr_o // Resulting address
);
	wire logic [AW:0] ones_w = {(AW+1){1'b1}};
	wire logic [5:0] shamt_w = {1'b0, blk_n_i} + 6'h01;
	wire logic [AW:0] mask_ext_w = ~(ones_w << shamt_w);
	wire logic [AW-1:0] mask_w = mask_ext_w[AW-1:0];
	wire logic [AW-1:0] lin_w = sub_i ? base_i - off_i : base_i + off_i;
	// Circular keeps the bits above the block, wraps within it
	assign addr_o = circ_i ? ((base_i & ~mask_w) | (lin_w & mask_w)) : lin_w;
endmodule : bdlu_agen

// file: bdlu_far_model.sv
// Far-side model: register files, condition source and data memory
`timescale 1ns/1ps
module bdlu_far_model (
	input wire logic clk_i, // Clock
	input wire logic rst_n_i, // Reset, low
	input wire logic rf_i, // Read file
	input wire logic [4:0] rb_i, // Base index
	input wire logic [4:0] ro_i, // Offset index
	output logic [31:0] base_o, // Base value
	output logic [31:0] off_o, // Offset value
	output logic [31:0] cond_o, // Condition value
	input wire logic bw_i, // Base write
	input wire logic bf_i, // Base file
	input wire logic [4:0] bi_i, // Base index
	input wire logic [31:0] bd_i, // Base data
	input wire logic req_i, // Memory read
	input wire logic [31:0] addr_i, // Address
	output logic [63:0] rdata_o, // Read data
	input wire logic we_i, // Dest write
	input wire logic wf_i, // Dest file
	input wire logic [4:0] wi_i, // Dest index
	input wire logic wp_i, // Pair write
	input wire logic [31:0] wlo_i, // Even data
	input wire logic [31:0] whi_i // Odd data
);
	logic [31:0] rf [64];
	logic [31:0] cond_val = 32'h0;
	logic [1:0] p_q;
	logic [31:0] a1_q;
	logic [31:0] a2_q;
	logic [63:0] last_q;
	function automatic logic [63:0] mem_dw(input logic [31:0] a);
		logic [63:0] d;
		for (int k = 0; k < 8; k++) d[8*k +: 8] = a[10:3] * 8'h1D + 8'(k * 37) ^ a[18:11];
		return d;
	endfunction : mem_dw
	assign base_o = rf[{rf_i, rb_i}];
	assign off_o = rf[{rf_i, ro_i}];
	assign cond_o = cond_val;
	// Data stands only in E4, a changing pattern otherwise
	assign rdata_o = p_q[1] ? mem_dw(a2_q) : ~last_q;
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			p_q <= 2'h0;
			last_q <= 64'h0;
		end else begin
			p_q <= {p_q[0], req_i};
			a1_q <= addr_i;
			a2_q <= a1_q;
			last_q <= rdata_o;
			if (bw_i) rf[{bf_i, bi_i}] <= bd_i;
			if (we_i) rf[{wf_i, wi_i}] <= wlo_i;
			if (we_i && wp_i) rf[{wf_i, wi_i | 5'h01}] <= whi_i;
		end
	end
endmodule : bdlu_far_model

// file: bdlu_top.sv
// Byte and doubleword load datapath with AHB-Lite control registers
//
// Local design decisions: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module bdlu_top
	import bdlu_pkg::*;
#(
	parameter int unsigned CNT_W = 16
) (
	input wire logic ref_clk_i, // Processor clock
	input wire logic rst_n_i, // Async reset, active low
	input wire logic hsel_i, // AHB slave select
	input wire logic [31:0] haddr_i, // AHB address
	input wire logic [1:0] htrans_i, // AHB transfer type
	input wire logic hwrite_i, // AHB write
	input wire logic [2:0] hsize_i, // AHB size, word only
	input wire logic hready_i, // AHB bus ready
	input wire logic [31:0] hwdata_i, // AHB write data
	output logic [31:0] hrdata_o, // AHB read data
	output logic hreadyout_o, // AHB slave ready
	output logic hresp_o, // AHB response, always OKAY
	input wire logic instr_valid_i, // Instruction issued this cycle
	input wire logic [31:0] instr_i, // Instruction word
	output logic rd_base_file_o, // Base/offset file, 0 A 1 B
	output logic [4:0] rd_base_idx_o, // Base register number
	output logic [4:0] rd_off_idx_o, // Offset register number
	output logic [3:0] cond_sel_o, // Condition field and zero bit
	output logic d_unit_o, // Data unit, 0 side one 1 side two
	input wire logic [31:0] base_data_i, // Base value in E1
	input wire logic [31:0] offset_data_i, // Offset value in E1
	input wire logic [31:0] cond_data_i, // Condition register in E1
	output logic base_wr_en_o, // Base update strobe
	output logic base_wr_file_o, // Base update file
	output logic [4:0] base_wr_idx_o, // Base update register
	output logic [31:0] base_wr_data_o, // Base update value
	output logic mem_req_o, // Memory read strobe
	output logic [31:0] mem_addr_o, // Byte address
	output logic mem_dw_o, // Doubleword access
	input wire logic [63:0] mem_rdata_i, // Aligned doubleword, byte k at [8k+7:8k]
	output logic wr_en_o, // Destination write strobe
	output logic wr_file_o, // Destination file, 0 A 1 B
	output logic [4:0] wr_idx_o, // Destination (even for pairs)
	output logic wr_pair_o, // Pair write, odd gets hi
	output logic [31:0] wr_data_lo_o, // Data for dst or even reg
	output logic [31:0] wr_data_hi_o // Data for odd reg
);
	localparam int unsigned PIPE_N = BDLU_LOAD_DELAY_SLOTS - 1;

	function automatic bdlu_kind_t bdlu_kind(input logic [31:0] w);
		logic [2:0] op;
		logic byte_op;
		op = w[BDLU_FLD_OP_LSB +: 3];
		byte_op = (op == BDLU_OP_SBYTE) || (op == BDLU_OP_UBYTE);
		if (w[BDLU_FLD_FMT_LSB +: 2] == BDLU_FMT_LONG && byte_op) begin
			return BDLU_KIND_LONG;
		end else if (w[BDLU_FLD_DW] && w[BDLU_FLD_FMT_LSB +: 5] == BDLU_DDW_SIG) begin
			return BDLU_KIND_DDW;
		end else if (!w[BDLU_FLD_DW] && w[BDLU_FLD_FMT_LSB +: 2] == BDLU_FMT_SHORT && byte_op) begin
			return BDLU_KIND_SHORT;
		end else begin
			return BDLU_KIND_NONE;
		end
	endfunction : bdlu_kind

	// Control registers
	logic [31:0] amr_q;
	logic [31:0] ctrl_q;
	logic [CNT_W-1:0] ld_cnt_q;
	logic [CNT_W-1:0] nop_cnt_q;
	logic wr_pend_q;
	logic [11:0] wr_addr_q;
	logic [31:0] hrdata_q;
	logic hreadyout_q;

	// Decode stage
	logic d_valid_q;
	logic [31:0] instr_q;
	logic rd_base_file_q;
	logic [4:0] rd_base_idx_q;
	logic [4:0] rd_off_idx_q;
	logic [3:0] cond_sel_q;
	logic d_unit_q;

	// Address stage outputs
	logic mem_req_q;
	logic [31:0] mem_addr_q;
	logic mem_dw_q;
	logic base_wr_en_q;
	logic base_wr_file_q;
	logic [4:0] base_wr_idx_q;
	logic [31:0] base_wr_data_q;
	bdlu_ctx_t ctx_q [PIPE_N];

	// Result outputs
	logic wr_en_q;
	logic wr_file_q;
	logic [4:0] wr_idx_q;
	logic wr_pair_q;
	logic [31:0] wr_lo_q;
	logic [31:0] wr_hi_q;

	// Register bus decode
	wire logic ahb_take_w = hsel_i && htrans_i[1] && hready_i;
	wire logic [11:0] ahb_off_w = haddr_i[11:0];
	wire logic rd_amr_w = (ahb_off_w == BDLU_OFF_AMR);
	wire logic rd_ctrl_w = (ahb_off_w == BDLU_OFF_CTRL);
	wire logic rd_stat_w = (ahb_off_w == BDLU_OFF_STAT);
	wire logic [31:0] stat_w = {nop_cnt_q, ld_cnt_q};
	wire logic [31:0] rd_mux_w = rd_amr_w ? amr_q :
		rd_ctrl_w ? ctrl_q :
		rd_stat_w ? stat_w : 32'h00000000;
	wire logic wr_amr_w = wr_pend_q && (wr_addr_q == BDLU_OFF_AMR);
	wire logic wr_ctrl_w = wr_pend_q && (wr_addr_q == BDLU_OFF_CTRL);
	wire logic wr_stat_w = wr_pend_q && (wr_addr_q == BDLU_OFF_STAT);

	// Issue decode toward the operand read ports
	wire bdlu_kind_t kind_i_w = bdlu_kind(instr_i);
	wire logic is_long_i_w = (kind_i_w == BDLU_KIND_LONG);
	wire logic y_i_w = instr_i[BDLU_FLD_Y];
	wire logic [4:0] long_base_w = y_i_w ? BDLU_REG_BASE15 : BDLU_REG_GBASE14;
	wire logic base_file_i_w = is_long_i_w ? 1'b1 : y_i_w;
	wire logic [4:0] base_idx_i_w = is_long_i_w ? long_base_w : instr_i[BDLU_FLD_BASE_LSB +: 5];
	wire logic unit_i_w = is_long_i_w ? 1'b1 : y_i_w;

	// E1 decode
	wire bdlu_kind_t kind_w = bdlu_kind(instr_q);
	wire logic is_long_w = (kind_w == BDLU_KIND_LONG);
	wire logic is_ddw_w = (kind_w == BDLU_KIND_DDW);
	wire logic [3:0] mode_w = instr_q[BDLU_FLD_MODE_LSB +: 4];
	wire logic [2:0] creg_w = instr_q[BDLU_FLD_CREG_LSB +: 3];
	wire logic z_w = instr_q[BDLU_FLD_Z];
	wire logic [4:0] dst_w = instr_q[BDLU_FLD_DST_LSB +: 5];
	// Unconditional only for creg 0 with z 0; the reserved pair squashes
	wire logic cond_ok_w = (creg_w == 3'h0) ? !z_w :
		(z_w ? (cond_data_i == 32'h00000000) : (cond_data_i != 32'h00000000));
	wire logic mode_ok_w = is_long_w || mode_w[3] || !mode_w[1];
	wire logic known_w = d_valid_q && (kind_w != BDLU_KIND_NONE);
	wire logic go_w = known_w && cond_ok_w && mode_ok_w;
	wire logic squash_w = known_w && !cond_ok_w;

	// Offset selection and scaling
	wire logic [31:0] long_cst_w = {17'h00000, instr_q[BDLU_FLD_LCST_LSB +: 15]};
	wire logic [31:0] short_cst_w = {27'h0000000, instr_q[BDLU_FLD_OFF_LSB +: 5]};
	// Defaults and parenthesised byte offsets arrive pre-folded in the field
	wire logic [31:0] raw_off_w = is_long_w ? long_cst_w :
		(mode_w[2] ? offset_data_i : short_cst_w);
	wire logic [31:0] scaled_off_w = is_ddw_w ? {raw_off_w[31-BDLU_DDW_SHIFT:0], 3'h0} :
		raw_off_w;
	wire logic sub_w = !is_long_w && !mode_w[0];

	// Circular selection from the addressing mode register
	wire logic circ_idx_w = (rd_base_idx_q >= BDLU_CIRC_LO) && (rd_base_idx_q <= BDLU_CIRC_HI);
	wire logic [2:0] amr_fi_w = {rd_base_file_q, rd_base_idx_q[1:0]};
	wire bdlu_amr_mode_t amr_mode_w = bdlu_amr_mode_t'(amr_q[{amr_fi_w, 1'b0} +: 2]);
	wire logic circ_mode_w = (amr_mode_w == BDLU_AMR_CIRC_BK0) ||
		(amr_mode_w == BDLU_AMR_CIRC_BK1);
	wire logic circ_w = !is_long_w && circ_idx_w && circ_mode_w;
	wire logic [4:0] blk_w = (amr_mode_w == BDLU_AMR_CIRC_BK0) ?
		amr_q[BDLU_AMR_BK0_LSB +: BDLU_AMR_BLK_W] : amr_q[BDLU_AMR_BK1_LSB +: BDLU_AMR_BLK_W];

	wire logic [31:0] calc_w;
	wire logic post_w = !is_long_w && mode_w[3] && mode_w[1];
	wire logic modify_w = !is_long_w && mode_w[3];
	wire logic [31:0] acc_addr_w = post_w ? base_data_i : calc_w;
	wire logic [4:0] dst_idx_w = is_ddw_w ? {dst_w[4:1], 1'b0} : dst_w;
	wire bdlu_ctx_t ctx_d = '{valid: go_w, dw: is_ddw_w,
		sgn: (instr_q[BDLU_FLD_OP_LSB +: 3] == BDLU_OP_SBYTE),
		file: instr_q[BDLU_FLD_S], idx: dst_idx_w, lane: acc_addr_w[2:0]};

	bdlu_agen #(
		.AW(32)
	) bdlu_agen_i (
		.base_i(base_data_i),
		.off_i(scaled_off_w),
		.sub_i(sub_w),
		.circ_i(circ_w),
		.blk_n_i(blk_w),
		.addr_o(calc_w)
	);

	// Result formatting in E4, written out in E5
	wire bdlu_ctx_t ctx_e4_w = ctx_q[PIPE_N-1];
	wire logic big_w = ctrl_q[BDLU_CTRL_BIG_ENDIAN];
	wire logic [7:0] byte_w = mem_rdata_i[{ctx_e4_w.lane, 3'h0} +: 8];
	wire logic [31:0] byte_ext_w = {{24{ctx_e4_w.sgn & byte_w[7]}}, byte_w};
	wire logic [31:0] w0_w = mem_rdata_i[31:0];
	wire logic [31:0] w1_w = mem_rdata_i[63:32];
	wire logic [31:0] w0_be_w = {w0_w[7:0], w0_w[15:8], w0_w[23:16], w0_w[31:24]};
	wire logic [31:0] w1_be_w = {w1_w[7:0], w1_w[15:8], w1_w[23:16], w1_w[31:24]};
	wire logic [31:0] even_w = big_w ? w1_be_w : w0_w;
	wire logic [31:0] odd_w = big_w ? w0_be_w : w1_w;

	wire logic ld_inc_w = ctx_e4_w.valid;
	wire logic [CNT_W-1:0] ld_base_w = wr_stat_w ? '0 : ld_cnt_q;
	wire logic [CNT_W-1:0] nop_base_w = wr_stat_w ? '0 : nop_cnt_q;

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 12'h000;
			hrdata_q <= 32'h00000000;
			hreadyout_q <= 1'b0;
		end else begin
			wr_pend_q <= ahb_take_w && hwrite_i;
			wr_addr_q <= ahb_off_w;
			hrdata_q <= (ahb_take_w && !hwrite_i) ? rd_mux_w : 32'h00000000;
			hreadyout_q <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			amr_q <= BDLU_AMR_RST;
			ctrl_q <= BDLU_CTRL_RST;
		end else begin
			if (wr_amr_w) begin
				amr_q <= hwdata_i;
			end
			if (wr_ctrl_w) begin
				ctrl_q <= {31'h00000000, hwdata_i[BDLU_CTRL_BIG_ENDIAN]};
			end
		end
	end

	// A clear in the same cycle restarts from zero and still adds that cycle's count
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ld_cnt_q <= '0;
			nop_cnt_q <= '0;
		end else begin
			ld_cnt_q <= ld_base_w + CNT_W'(ld_inc_w);
			nop_cnt_q <= nop_base_w + CNT_W'(squash_w);
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			d_valid_q <= 1'b0;
			instr_q <= 32'h00000000;
			rd_base_file_q <= 1'b0;
			rd_base_idx_q <= 5'h00;
			rd_off_idx_q <= 5'h00;
			cond_sel_q <= 4'h0;
			d_unit_q <= 1'b0;
		end else begin
			d_valid_q <= instr_valid_i;
			instr_q <= instr_i;
			rd_base_file_q <= base_file_i_w;
			rd_base_idx_q <= base_idx_i_w;
			rd_off_idx_q <= instr_i[BDLU_FLD_OFF_LSB +: 5];
			cond_sel_q <= instr_i[BDLU_FLD_Z +: 4];
			d_unit_q <= unit_i_w;
		end
	end

	// Address leaves at end of E1; base update visible one cycle later
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mem_req_q <= 1'b0;
			mem_addr_q <= 32'h00000000;
			mem_dw_q <= 1'b0;
			base_wr_en_q <= 1'b0;
			base_wr_file_q <= 1'b0;
			base_wr_idx_q <= 5'h00;
			base_wr_data_q <= 32'h00000000;
		end else begin
			mem_req_q <= go_w;
			mem_addr_q <= acc_addr_w;
			mem_dw_q <= is_ddw_w;
			base_wr_en_q <= go_w && modify_w;
			base_wr_file_q <= rd_base_file_q;
			base_wr_idx_q <= rd_base_idx_q;
			base_wr_data_q <= calc_w;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < PIPE_N; i++) begin
				ctx_q[i] <= '0;
			end
		end else begin
			ctx_q[0] <= ctx_d;
			for (int i = 1; i < PIPE_N; i++) begin
				ctx_q[i] <= ctx_q[i-1];
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_en_q <= 1'b0;
			wr_file_q <= 1'b0;
			wr_idx_q <= 5'h00;
			wr_pair_q <= 1'b0;
			wr_lo_q <= 32'h00000000;
			wr_hi_q <= 32'h00000000;
		end else begin
			wr_en_q <= ctx_e4_w.valid;
			wr_file_q <= ctx_e4_w.file;
			wr_idx_q <= ctx_e4_w.idx;
			wr_pair_q <= ctx_e4_w.valid && ctx_e4_w.dw;
			wr_lo_q <= ctx_e4_w.dw ? even_w : byte_ext_w;
			wr_hi_q <= ctx_e4_w.dw ? odd_w : 32'h00000000;
		end
	end

	assign hrdata_o = hrdata_q;
	assign hreadyout_o = hreadyout_q;
	assign hresp_o = 1'b0;
	assign rd_base_file_o = rd_base_file_q;
	assign rd_base_idx_o = rd_base_idx_q;
	assign rd_off_idx_o = rd_off_idx_q;
	assign cond_sel_o = cond_sel_q;
	assign d_unit_o = d_unit_q;
	assign base_wr_en_o = base_wr_en_q;
	assign base_wr_file_o = base_wr_file_q;
	assign base_wr_idx_o = base_wr_idx_q;
	assign base_wr_data_o = base_wr_data_q;
	assign mem_req_o = mem_req_q;
	assign mem_addr_o = mem_addr_q;
	assign mem_dw_o = mem_dw_q;
	assign wr_en_o = wr_en_q;
	assign wr_file_o = wr_file_q;
	assign wr_idx_o = wr_idx_q;
	assign wr_pair_o = wr_pair_q;
	assign wr_data_lo_o = wr_lo_q;
	assign wr_data_hi_o = wr_hi_q;

	// Checks
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	wire logic long_issue_w = instr_valid_i && (kind_i_w == BDLU_KIND_LONG);
	wire logic ddw_issue_w = instr_valid_i && (kind_i_w == BDLU_KIND_DDW);
	wire logic ddw_pos_w = go_w && is_ddw_w && !circ_w && (mode_w == BDLU_MODE_POS_CST);

	a_long_base_sel: assert property (
		long_issue_w |=> rd_base_file_o &&
			rd_base_idx_o == ($past(instr_i[BDLU_FLD_Y]) ? 5'h0F : 5'h0E)
	) else $error("long byte load base register wrong");

	a_long_unit_two: assert property (
		long_issue_w |=> d_unit_o
	) else $error("long byte load not on side two");

	a_long_linear: assert property (
		go_w && is_long_w |=> mem_addr_o == $past(base_data_i + long_cst_w)
	) else $error("long byte load address not base plus constant");

	a_ddw_side: assert property (
		ddw_issue_w |=> d_unit_o == $past(instr_i[BDLU_FLD_Y]) &&
			rd_base_file_o == $past(instr_i[BDLU_FLD_Y])
	) else $error("doubleword unit and file differ from y");

	a_byte_fill: assert property (
		wr_en_o && !wr_pair_o |-> wr_data_lo_o[31:8] == 24'h000000 ||
			(wr_data_lo_o[31:8] == 24'hFFFFFF && wr_data_lo_o[7])
	) else $error("byte result upper bits not a proper fill");

	a_load_delay: assert property (
		go_w |-> ##4 wr_en_o
	) else $error("loaded data not written in fifth stage");

	a_base_update: assert property (
		go_w && modify_w |=> base_wr_en_o && base_wr_data_o == $past(calc_w)
	) else $error("base update missing or late");

	a_pair_even: assert property (
		wr_pair_o |-> !wr_idx_o[0]
	) else $error("pair destination not even");

	a_ddw_scale: assert property (
		ddw_pos_w |=> mem_addr_o ==
			$past(base_data_i) + 32'({$past(instr_q[BDLU_FLD_OFF_LSB +: 5]), 3'h0})
	) else $error("doubleword offset not scaled by eight");

	a_post_addr: assert property (
		go_w && post_w |=> mem_addr_o == $past(base_data_i)
	) else $error("post-modify access not at old base");

	a_squash_quiet: assert property (
		squash_w |=> !mem_req_o && !base_wr_en_o ##3 !wr_en_o
	) else $error("false condition still accessed or wrote");

	c_ddw_post: cover property (go_w && is_ddw_w && post_w);
	c_circ_load: cover property (go_w && circ_w);
	c_big_pair: cover property (wr_en_o && wr_pair_o && big_w);
	c_squash: cover property (squash_w);
endmodule : bdlu_top

// file: byte_and_doubleword_load_unit_test.sv
// Self-checking bench for the byte and doubleword load unit
`timescale 1ns/1ps
module byte_and_doubleword_load_unit_test;
	import bdlu_pkg::*;
	localparam logic [31:0] MODE_ADDR = 32'h00000000;
	logic ref_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic iv = 1'b0;
	logic [31:0] ins = 32'h0;
	wire logic [31:0] hrdata, bd, od, cd, maddr, wlo, whi, bwd;
	wire logic [63:0] mrd;
	wire logic hready, hresp, rbf, du, bwe, bwf, mreq, mdw, we, wf, wp;
	wire logic [4:0] rbi, roi, bwi, wi;
	wire logic [3:0] csel;
	int fail_count = 0;
	int cmp_count = 0;
	int nld = 0;
	int nsq = 0;
	logic e1f, e1u, big, y, s, dw;
	logic [4:0] e1i, bi, oi, dst;
	logic [31:0] r, bv, ov, sc, calc, ea, old;
	logic [63:0] d;
	logic [3:0] md;
	logic [2:0] op;
	logic [3:0] czt [5] = '{4'h2, 4'h2, 4'h3, 4'h3, 4'h1};
	logic [31:0] cvt [5] = '{32'h0, 32'h5, 32'h0, 32'h7, 32'h0};
	logic [4:0] gov = 5'b00110;
	always #2 ref_clk_i = ~ref_clk_i;
	bdlu_top #(.CNT_W(16)) bdlu_top_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .hsel_i(1'b1),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hready_i(hready),
		.hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
		.instr_valid_i(iv), .instr_i(ins), .rd_base_file_o(rbf), .rd_base_idx_o(rbi),
		.rd_off_idx_o(roi), .cond_sel_o(csel), .d_unit_o(du), .base_data_i(bd),
		.offset_data_i(od), .cond_data_i(cd), .base_wr_en_o(bwe), .base_wr_file_o(bwf),
		.base_wr_idx_o(bwi), .base_wr_data_o(bwd), .mem_req_o(mreq), .mem_addr_o(maddr),
		.mem_dw_o(mdw), .mem_rdata_i(mrd), .wr_en_o(we), .wr_file_o(wf), .wr_idx_o(wi),
		.wr_pair_o(wp), .wr_data_lo_o(wlo), .wr_data_hi_o(whi));
	bdlu_far_model bdlu_far_model_i (.clk_i(ref_clk_i), .rst_n_i(rst_n_i), .rf_i(rbf),
		.rb_i(rbi), .ro_i(roi), .base_o(bd), .off_o(od), .cond_o(cd), .bw_i(bwe), .bf_i(bwf),
		.bi_i(bwi), .bd_i(bwd), .req_i(mreq), .addr_i(maddr), .rdata_o(mrd), .we_i(we),
		.wf_i(wf), .wi_i(wi), .wp_i(wp), .wlo_i(wlo), .whi_i(whi));
	function automatic logic [31:0] rfv(input logic [5:0] i);
		return bdlu_far_model_i.rf[i];
	endfunction : rfv
	function automatic logic [31:0] bext(input logic [31:0] a, input logic sx);
		logic [63:0] m;
		logic [7:0] b;
		m = bdlu_far_model_i.mem_dw(a);
		b = m[8*a[2:0] +: 8];
		return sx ? {{24{b[7]}}, b} : {24'h0, b};
	endfunction : bext
	function automatic logic [31:0] bsw(input logic [31:0] w);
		return {w[7:0], w[15:8], w[23:16], w[31:24]};
	endfunction : bsw
	function automatic logic [31:0] mk(input logic [3:0] cz, input logic [14:0] mid,
		input logic [4:0] lo);
		return {cz, dst, mid, y, lo, s, 1'b0};
	endfunction : mk
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge ref_clk_i);
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge ref_clk_i); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge ref_clk_i); while (hready !== 1'b1);
		rd = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask : ahb
	task automatic issue(input logic [31:0] i, input logic go, input logic bw);
		@(posedge ref_clk_i);
		ins <= i;
		iv <= 1'b1;
		@(posedge ref_clk_i);
		iv <= 1'b0;
		#1;
		e1f = rbf;
		e1u = du;
		e1i = rbi;
		chk("cond_sel", {28'h0, i[31:28]}, {28'h0, csel});
		@(posedge ref_clk_i);
		#1;
		chk("mem_req", {31'h0, go}, {31'h0, mreq});
		if (go) chk("mem_addr", ea, maddr);
		if (go) chk("mem_dw", {31'h0, dw}, {31'h0, mdw});
		chk("base_wr", {31'h0, go & bw}, {31'h0, bwe});
		repeat (3) @(posedge ref_clk_i);
		#1;
		chk("wr_en", {31'h0, go}, {31'h0, we});
		if (go) chk("wr_pair", {31'h0, dw}, {31'h0, wp});
		if (go && !dw) chk("hi_zero", 32'h0, whi);
		@(posedge ref_clk_i);
		#1;
		if (go) nld++;
		else nsq++;
	endtask : issue
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_of_test
	initial begin
		#100000;
		fail_count++;
		end_of_test();
	end
	initial begin
		void'($urandom(32'he713));
		for (int i = 0; i < 64; i++) bdlu_far_model_i.rf[i] = $urandom;
		repeat (16) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		ahb(1'b1, 32'h0000000C, 32'h00005A5A, r);
		// Mode, control, status and one unmapped word all read zero
		for (int k = 0; k < 4; k++) begin
			ahb(1'b0, 32'(4 * k), 32'h0, r);
			chk("reg_rst", 32'h0, r);
		end
		for (int n = 0; n < 16; n++) begin
			y = n[0];
			s = n[2];
			dw = 1'b0;
			op = n[1] ? BDLU_OP_SBYTE : BDLU_OP_UBYTE;
			dst = 5'(16 + $urandom_range(15));
			r = $urandom_range(32767);
			ea = rfv({1'b1, 4'h7, y}) + r;
			issue(mk(4'h0, r[14:0], {op, BDLU_FMT_LONG}), 1'b1, 1'b0);
			chk("unit", 32'h1, {31'h0, e1u});
			chk("base_sel", {27'h0, 5'(14 + y)}, {27'h0, e1i});
			chk("byte", bext(ea, n[1]), rfv({s, dst}));
		end
		for (int e = 0; e < 2; e++) begin
			big = e[0];
			ahb(1'b1, {20'h0, BDLU_OFF_CTRL}, {31'h0, big}, r);
			ahb(1'b0, {20'h0, BDLU_OFF_CTRL}, 32'h0, r);
			chk("ctrl", {31'h0, big}, r);
			for (int n = 0; n < 24; n++) begin
				dw = n[0];
				y = 1'($urandom);
				s = 1'($urandom);
				op = n[1] ? BDLU_OP_SBYTE : BDLU_OP_UBYTE;
				md = 4'($urandom);
				if (!md[3] && md[1]) md[3] = 1'b1;
				bi = 5'($urandom_range(7));
				oi = 5'(8 + $urandom_range(7));
				dst = 5'(16 + 2 * $urandom_range(7));
				if (dw) bdlu_far_model_i.rf[{y, bi}][2:0] = 3'h0;
				bv = rfv({y, bi});
				ov = md[2] ? rfv({y, oi}) : {27'h0, oi};
				sc = dw ? ov << 3 : ov;
				calc = md[0] ? bv + sc : bv - sc;
				ea = (md[3] && md[1]) ? bv : calc;
				r = mk(4'h0, {bi, oi, md, dw}, dw ? BDLU_DDW_SIG : {op, BDLU_FMT_SHORT});
				issue(r, 1'b1, md[3]);
				chk("unit", {31'h0, y}, {31'h0, e1u});
				chk("file", {31'h0, y}, {31'h0, e1f});
				d = bdlu_far_model_i.mem_dw(ea);
				if (dw) begin
					chk("even", big ? bsw(d[63:32]) : d[31:0], rfv({s, dst}));
					chk("odd", big ? bsw(d[31:0]) : d[63:32], rfv({s, dst | 5'h1}));
				end else begin
					chk("byte", bext(ea, n[1]), rfv({s, dst}));
				end
				if (md[3]) chk("base", calc, rfv({y, bi}));
			end
		end
		ahb(1'b1, MODE_ADDR, 32'h00030001, r);
		y = 1'b0;
		s = 1'b0;
		dw = 1'b1;
		dst = 5'h10;
		bdlu_far_model_i.rf[4] = 32'h000040B8;
		ea = 32'h000040B0;
		issue(mk(4'h0, {5'h04, 5'h01, 4'h9, 1'b1}, BDLU_DDW_SIG), 1'b1, 1'b1);
		chk("circ_base", ea, rfv(6'h04));
		ahb(1'b1, MODE_ADDR, 32'h0, r);
		for (int n = 0; n < 5; n++) begin
			y = 1'b1;
			s = 1'b1;
			dw = 1'b0;
			dst = 5'h11;
			bdlu_far_model_i.cond_val = cvt[n];
			old = rfv({s, dst});
			ea = rfv(6'h2F) + 32'h40;
			issue(mk(czt[n], 15'h0040, {BDLU_OP_UBYTE, BDLU_FMT_LONG}), gov[n], 1'b0);
			chk("cond_dst", gov[n] ? bext(ea, 1'b0) : old, rfv({s, dst}));
		end
		ahb(1'b0, {20'h0, BDLU_OFF_STAT}, 32'h0, r);
		chk("stat", {nsq[15:0], nld[15:0]}, r);
		ahb(1'b1, {20'h0, BDLU_OFF_STAT}, 32'h0, r);
		ahb(1'b0, {20'h0, BDLU_OFF_STAT}, 32'h0, r);
		chk("stat_clr", 32'h0, r);
		issue(mk(4'h0, {5'h04, 5'h08, 4'h6, 1'b0}, {BDLU_OP_SBYTE, BDLU_FMT_SHORT}), 1'b0, 1'b0);
		end_of_test();
	end
endmodule : byte_and_doubleword_load_unit_test
